/* File: hdl/pasc_params.svh */
// Purpose: Offsets, field positions, reset values and widths for the
//          auto-shutdown control block.
// Assumes: 8-bit register port, one clock at 125 MHz.
// Notes:   Included by the design file; definitions only.
//
// Summary of operation
// R01: Enabled selected source forces shutdown, status, flag
// R02: Auto-restart resumes PWM once source releases
// R03: Without auto-restart, software clears status to resume
// R04: Control bits four to one read zero
// R05: Override forces shutdown levels, no interrupt flag
// R06: Override ignored while auto-shutdown disabled
// R07: Software setting status acts as hardware event
// R08: Zero duty always off, full duty always on
`ifndef PASC_PARAMS_SVH
`define PASC_PARAMS_SVH

// ==========================================================
// Widths
// ==========================================================
`define PASC_DATA_W 8
`define PASC_ADDR_W 3
`define PASC_NSRC 4
`define PASC_NOUT 2

// ==========================================================
// Register offsets
// ==========================================================
`define PASC_OFS_CONTROL 3'h0
`define PASC_OFS_SOURCE 3'h1
`define PASC_OFS_LEVEL 3'h2
`define PASC_OFS_PERIOD 3'h3
`define PASC_OFS_DUTY 3'h4
`define PASC_OFS_INT_STATUS 3'h5
`define PASC_OFS_INT_MASK 3'h6

// ==========================================================
// Control and interrupt register fields
// ==========================================================
`define PASC_BIT_STATUS 7
`define PASC_BIT_ENABLE 6
`define PASC_BIT_RESTART 5
`define PASC_BIT_OVERRIDE 0
`define PASC_BIT_INT_SHUTDOWN 0

// ==========================================================
// Reset values
// ==========================================================
`define PASC_RST_BYTE 8'h00
`define PASC_RST_PERIOD 8'hff
`define PASC_RST_LEVEL 2'h0

`endif

/* File: hdl/pasc_pkg.sv */
// Purpose: Types shared by the auto-shutdown control block.
// Assumes: Nothing beyond the parameter header.
// Notes:   Output mode states are one-hot.
package pasc_pkg;

   // ==========================================================
   // Output mode
   // ==========================================================
   typedef enum logic [2:0] {
      PASC_RUN = 3'h1,
      PASC_SHUTDOWN = 3'h2,
      PASC_FORCED = 3'h4
   } pasc_mode_type;

endpackage : pasc_pkg

/* File: hdl/pasc_top.sv */
// Purpose: PWM generator with auto-shutdown, auto-restart and override.
// Assumes: Shutdown sources are asynchronous pins; register port is on clk.
// Notes:   Read data appear in the cycle after the read strobe.
`include "pasc_params.svh"

module pasc_top
   import pasc_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Register port
   input wire logic [`PASC_ADDR_W-1:0] reg_addr,
   input wire logic [`PASC_DATA_W-1:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [`PASC_DATA_W-1:0] reg_rdata,
   // Shutdown sources from pins
   input wire logic [`PASC_NSRC-1:0] shutdown_source,
   // PWM outputs to the switching stage
   output logic [`PASC_NOUT-1:0] pwm_out,
   // Interrupt
   output logic irq
);

   // ==========================================================
   // Registers
   // ==========================================================
   logic shutdown_event_status;
   logic auto_shutdown_enable;
   logic auto_restart_enable;
   logic shutdown_override;
   logic [`PASC_NSRC-1:0] shutdown_source_select;
   logic [`PASC_NOUT-1:0] shutdown_output_level;
   logic [`PASC_DATA_W-1:0] pwm_period;
   logic [`PASC_DATA_W-1:0] pwm_duty;
   logic shutdown_interrupt_flag;
   logic int_mask;

   // ==========================================================
   // Address decode
   // ==========================================================
   wire logic sel_control = (reg_addr == `PASC_OFS_CONTROL);
   wire logic sel_source = (reg_addr == `PASC_OFS_SOURCE);
   wire logic sel_level = (reg_addr == `PASC_OFS_LEVEL);
   wire logic sel_period = (reg_addr == `PASC_OFS_PERIOD);
   wire logic sel_duty = (reg_addr == `PASC_OFS_DUTY);
   wire logic sel_int_status = (reg_addr == `PASC_OFS_INT_STATUS);
   wire logic sel_int_mask = (reg_addr == `PASC_OFS_INT_MASK);

   wire logic wr_control = reg_write && sel_control;
   wire logic wr_source = reg_write && sel_source;
   wire logic wr_level = reg_write && sel_level;
   wire logic wr_period = reg_write && sel_period;
   wire logic wr_duty = reg_write && sel_duty;
   wire logic wr_int_status = reg_write && sel_int_status;
   wire logic wr_int_mask = reg_write && sel_int_mask;

   // ==========================================================
   // Source synchroniser
   // ==========================================================
   logic [`PASC_NSRC-1:0] src_meta;
   logic [`PASC_NSRC-1:0] src_sync;

   // Pins are asynchronous; only src_sync is read by logic
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         src_meta <= '0;
         src_sync <= '0;
      end else begin
         src_meta <= shutdown_source;
         src_sync <= src_meta;
      end
   end

   // Any selected source high at logic one
   wire logic source_hit = |(src_sync & shutdown_source_select);

   // ==========================================================
   // Shutdown status
   // ==========================================================
   // Hardware detection only counts while auto-shutdown is enabled
   wire logic hw_shutdown = auto_shutdown_enable && source_hit; // [R01]
   // Software write of one behaves like a detected event
   wire logic sw_set = wr_control && reg_wdata[`PASC_BIT_STATUS]; // [R07]
   // Software write of zero clears the status (no auto-restart needed)
   wire logic sw_clear = wr_control && !reg_wdata[`PASC_BIT_STATUS]; // [R03]
   // Auto-restart clears once the source has gone away
   wire logic auto_clear = auto_restart_enable && !source_hit; // [R02]

   // Set wins over any clear in the same cycle
   wire logic next_shutdown_event_status =
      (hw_shutdown || sw_set) ? 1'b1 :
      (sw_clear || auto_clear) ? 1'b0 :
      shutdown_event_status; // [R01] [R02] [R03] [R07]

   // Flag raises on entry into shutdown, not on the override
   wire logic shutdown_entry =
      next_shutdown_event_status && !shutdown_event_status; // [R01] [R05]

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         shutdown_event_status <= 1'b0;
      end else begin
         shutdown_event_status <= next_shutdown_event_status;
      end
   end

   // ==========================================================
   // Configuration registers
   // ==========================================================
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         auto_shutdown_enable <= 1'b0;
         auto_restart_enable <= 1'b0;
         shutdown_override <= 1'b0;
      end else if (wr_control) begin
         auto_shutdown_enable <= reg_wdata[`PASC_BIT_ENABLE];
         auto_restart_enable <= reg_wdata[`PASC_BIT_RESTART];
         shutdown_override <= reg_wdata[`PASC_BIT_OVERRIDE];
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         shutdown_source_select <= '0;
      end else if (wr_source) begin
         shutdown_source_select <= reg_wdata[`PASC_NSRC-1:0];
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         shutdown_output_level <= `PASC_RST_LEVEL;
      end else if (wr_level) begin
         shutdown_output_level <= reg_wdata[`PASC_NOUT-1:0];
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         pwm_period <= `PASC_RST_PERIOD;
      end else if (wr_period) begin
         pwm_period <= reg_wdata;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         pwm_duty <= `PASC_RST_BYTE;
      end else if (wr_duty) begin
         pwm_duty <= reg_wdata;
      end
   end

   // ==========================================================
   // Interrupt status and mask
   // ==========================================================
   // Write one to clear; a new entry in the same cycle wins
   wire logic int_clear = wr_int_status && reg_wdata[`PASC_BIT_INT_SHUTDOWN];
   wire logic next_shutdown_interrupt_flag =
      shutdown_entry ? 1'b1 :
      int_clear ? 1'b0 :
      shutdown_interrupt_flag; // [R01]

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         shutdown_interrupt_flag <= 1'b0;
      end else begin
         shutdown_interrupt_flag <= next_shutdown_interrupt_flag;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         int_mask <= 1'b0;
      end else if (wr_int_mask) begin
         int_mask <= reg_wdata[`PASC_BIT_INT_SHUTDOWN];
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         irq <= 1'b0;
      end else begin
         irq <= next_shutdown_interrupt_flag && int_mask;
      end
   end

   // ==========================================================
   // PWM time base
   // ==========================================================
   logic [`PASC_DATA_W-1:0] pwm_count;
   wire logic period_end = (pwm_count >= pwm_period);
   wire logic [`PASC_DATA_W-1:0] next_pwm_count =
      period_end ? '0 : pwm_count + 8'h01;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         pwm_count <= '0;
      end else begin
         pwm_count <= next_pwm_count;
      end
   end

   // Zero duty never turns on; duty above period never turns off
   wire logic duty_off = (pwm_duty == 8'h00); // [R08]
   wire logic duty_full = (pwm_duty > pwm_period); // [R08]
   wire logic pwm_on =
      duty_off ? 1'b0 :
      duty_full ? 1'b1 :
      (next_pwm_count < pwm_duty); // [R08]

   // ==========================================================
   // Output mode
   // ==========================================================
   pasc_mode_type mode;
   pasc_mode_type next_mode;

   // Override only counts with auto-shutdown enabled
   wire logic override_active = auto_shutdown_enable && shutdown_override; // [R05] [R06]

   always_comb begin
      case (1'b1)
         next_shutdown_event_status: next_mode = PASC_SHUTDOWN; // [R01] [R07]
         override_active: next_mode = PASC_FORCED; // [R05]
         default: next_mode = PASC_RUN; // [R02] [R03] [R06]
      endcase
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         mode <= PASC_RUN;
      end else begin
         mode <= next_mode;
      end
   end

   // Complementary pair in normal running
   wire logic [`PASC_NOUT-1:0] run_level = {~pwm_on, pwm_on};
   logic [`PASC_NOUT-1:0] next_pwm_out;

   always_comb begin
      case (next_mode)
         PASC_SHUTDOWN: next_pwm_out = shutdown_output_level; // [R01]
         PASC_FORCED: next_pwm_out = shutdown_output_level; // [R05]
         PASC_RUN: next_pwm_out = run_level;
         default: next_pwm_out = shutdown_output_level;
      endcase
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         pwm_out <= `PASC_RST_LEVEL;
      end else begin
         pwm_out <= next_pwm_out;
      end
   end

   // ==========================================================
   // Read path
   // ==========================================================
   // Bits four to one of control are not stored and read zero
   wire logic [`PASC_DATA_W-1:0] control_view = {
      shutdown_event_status,
      auto_shutdown_enable,
      auto_restart_enable,
      4'h0,
      shutdown_override
   }; // [R04]

   logic [`PASC_DATA_W-1:0] read_mux;

   always_comb begin
      read_mux = '0;
      case (reg_addr)
         `PASC_OFS_CONTROL: read_mux = control_view;
         `PASC_OFS_SOURCE: read_mux = {4'h0, shutdown_source_select};
         `PASC_OFS_LEVEL: read_mux = {6'h00, shutdown_output_level};
         `PASC_OFS_PERIOD: read_mux = pwm_period;
         `PASC_OFS_DUTY: read_mux = pwm_duty;
         `PASC_OFS_INT_STATUS: read_mux = {7'h00, shutdown_interrupt_flag};
         `PASC_OFS_INT_MASK: read_mux = {7'h00, int_mask};
         default: read_mux = '0;
      endcase
   end

   // Data stand only in the cycle after the strobe
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         reg_rdata <= '0;
      end else if (reg_read) begin
         reg_rdata <= read_mux;
      end else begin
         reg_rdata <= '0;
      end
   end

endmodule : pasc_top

/* File: tb/pasc_assertions.sv */
// Purpose: Port checker for pasc_top.
// Assumes: Register shadows are rebuilt here from the writes seen on the port.
// Notes:   Status is not visible at the ports, so holds are judged from writes.
module pasc_assertions (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Register port
   input wire logic [2:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   input wire logic [7:0] reg_rdata,
   // Pins
   input wire logic [3:0] shutdown_source,
   input wire logic [1:0] pwm_out,
   input wire logic irq
);
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================================================
   // Register shadows
   // ==========================================================
   logic [7:0] ctl, sel, lvl, per, dut, msk;
   wire en = ctl[6];
   wire hit = |(shutdown_source & sel[3:0]);
   wire [1:0] lv = lvl[1:0];

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         {ctl, sel, lvl, dut, msk} <= 40'h00_0000_0000;
         per <= 8'hff;
      end else if (reg_write) begin
         case (reg_addr)
            3'h0: ctl <= reg_wdata;
            3'h1: sel <= reg_wdata;
            3'h2: lvl <= reg_wdata;
            3'h3: per <= reg_wdata;
            3'h4: dut <= reg_wdata;
            3'h6: msk <= reg_wdata;
            default: ;
         endcase
      end
   end

   // ==========================================================
   // Properties
   // ==========================================================
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);

   // Three samples cover the two sync flops plus the status edge
   sequence s_fault;
      (en && hit && !reg_write)[*3];
   endsequence
   sequence s_sw_set;
      reg_write && reg_addr == 3'h0 && reg_wdata[7:6] == 2'b11;
   endsequence

   a_unimpl_read_zero: assert property (
      reg_read && reg_addr == 3'h0 |=> reg_rdata[4:1] == 4'h0)
      else $error("control bits four to one not zero");
   a_fault_level: assert property (s_fault |=> pwm_out == lv)
      else $error("pwm not at shutdown level after fault");
   a_fault_irq: assert property (s_fault ##0 msk[0] |=> irq)
      else $error("irq missing after fault");
   a_auto_restart: assert property (
      (en && ctl[5] && !ctl[0] && !hit && !reg_write)[*4] |-> pwm_out[1] != pwm_out[0])
      else $error("pwm did not restart");
   a_latch_hold: assert property (
      reg_write && reg_addr == 3'h0 && reg_wdata[7:5] == 3'b110 && !reg_wdata[0]
      ##1 (!reg_write)[*8] |-> pwm_out == lv)
      else $error("shutdown not held without restart");
   a_sw_irq: assert property ((s_sw_set and msk[0]) |=> irq)
      else $error("software event raised no irq");
   a_override_quiet: assert property (
      (en && ctl[0] && !hit && !reg_write)[*3] ##0 !irq |=> !irq && pwm_out == lv)
      else $error("override wrong level or raised irq");
   a_zero_duty: assert property (
      (!ctl[7] && !en && dut == 8'h00 && !reg_write)[*5] |-> pwm_out == 2'b10)
      else $error("zero duty not held off");
   a_full_duty: assert property (
      (!ctl[7] && !en && dut > per && !reg_write)[*5] |-> pwm_out == 2'b01)
      else $error("full duty not held on");
endmodule : pasc_assertions

/* File: tb/pasc_stage_model.sv */
// Purpose: Switching stage behind the PWM pins, with an over-current sense.
// Assumes: Bench asks for a fault by level on fault_req.
// Notes:   Only source line 0 is wired to a comparator; others stay low.
module pasc_stage_model (
   // Clock
   input wire logic clk,
   // Pins
   input wire logic [1:0] pwm_out,
   output logic [3:0] shutdown_source,
   // Bench side
   input wire logic fault_req,
   output int on_count
);
   timeunit 1ns;
   timeprecision 1ps;
   // Sense path answers a cycle late, unaligned with the PWM phase
   always_ff @(posedge clk) begin
      shutdown_source <= {3'b000, fault_req};
      on_count <= on_count + int'(pwm_out[0]);
   end
endmodule : pasc_stage_model

/* File: tb/testbench.sv */
// Purpose: Directed bench for pasc_top.
// Assumes: Duty 0 after each scenario, so running outputs read 2'b10.
// Notes:   Read data are taken one step after the edge that ends the strobe.
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic [2:0] reg_addr = 3'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_write = 1'b0;
   logic reg_read = 1'b0;
   logic fault = 1'b0;
   wire [7:0] reg_rdata;
   wire [3:0] shutdown_source;
   wire [1:0] pwm_out;
   wire irq;
   int on_count;
   int mismatches = 0;
   int n_tests = 0;

   always #4 clk = ~clk;

   pasc_top i_pasc_top (.clk(clk), .resetn(resetn), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
      .reg_rdata(reg_rdata), .shutdown_source(shutdown_source), .pwm_out(pwm_out), .irq(irq));
   pasc_stage_model i_pasc_stage_model (.clk(clk), .pwm_out(pwm_out),
      .shutdown_source(shutdown_source), .fault_req(fault), .on_count(on_count));

   // ==========================================================
   // Bus and check tasks
   // ==========================================================
   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clk);
      reg_write <= 1'b0;
      #1;
   endtask : wr
   task automatic rd(input logic [2:0] a, input logic [7:0] exp, input string name);
      @(posedge clk);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clk);
      reg_read <= 1'b0;
      #1;
      check(name, reg_rdata, exp);
   endtask : rd
   task automatic wait_c(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : wait_c
   task automatic set_fault(input logic v);
      @(posedge clk);
      fault <= v;
   endtask : set_fault

   // ==========================================================
   // Scenarios
   // ==========================================================
   task automatic t_regs;
      rd(3'h0, 8'h00, "control");
      rd(3'h3, 8'hff, "period");
      rd(3'h7, 8'h00, "unmapped");
      wr(3'h0, 8'h1f);
      rd(3'h0, 8'h01, "control");
      wr(3'h0, 8'h00);
   endtask : t_regs
   task automatic t_duty;
      logic [7:0] dv[3] = '{8'h00, 8'h04, 8'h02};
      int ev[3] = '{0, 8, 4};
      int c0;
      wr(3'h0, 8'h01);
      wr(3'h3, 8'h03);
      foreach (dv[i]) begin
         wr(3'h4, dv[i]);
         wait_c(3);
         c0 = on_count;
         wait_c(8);
         check("on_time", 8'(on_count - c0), 8'(ev[i]));
      end
      wr(3'h4, 8'h00);
   endtask : t_duty
   task automatic t_hw;
      wr(3'h1, 8'h01);
      wr(3'h2, 8'h03);
      wr(3'h6, 8'h01);
      wr(3'h0, 8'h60);
      set_fault(1'b1);
      wait_c(6);
      check("pwm_out", 8'(pwm_out), 8'h03);
      check("irq", 8'(irq), 8'h01);
      rd(3'h0, 8'he0, "control");
      rd(3'h5, 8'h01, "int_status");
      set_fault(1'b0);
      wait_c(6);
      check("pwm_out", 8'(pwm_out), 8'h02);
      rd(3'h0, 8'h60, "control");
      wr(3'h5, 8'h01);
      rd(3'h5, 8'h00, "int_status");
      check("irq", 8'(irq), 8'h00);
   endtask : t_hw
   task automatic t_latch;
      wr(3'h0, 8'h40);
      set_fault(1'b1);
      wait_c(6);
      set_fault(1'b0);
      wait_c(8);
      check("pwm_out", 8'(pwm_out), 8'h03);
      rd(3'h0, 8'hc0, "control");
      wr(3'h0, 8'h40);
      wait_c(2);
      check("pwm_out", 8'(pwm_out), 8'h02);
      wr(3'h5, 8'h01);
   endtask : t_latch
   task automatic t_sw;
      wr(3'h0, 8'hc0);
      wait_c(9);
      check("pwm_out", 8'(pwm_out), 8'h03);
      check("irq", 8'(irq), 8'h01);
      wr(3'h0, 8'h40);
      wr(3'h5, 8'h01);
      wr(3'h6, 8'h00);
      wr(3'h0, 8'hc0);
      wait_c(1);
      check("irq", 8'(irq), 8'h00);
      rd(3'h5, 8'h01, "int_status");
      wr(3'h0, 8'h40);
      wr(3'h5, 8'h01);
      wr(3'h6, 8'h01);
   endtask : t_sw
   task automatic t_ovr;
      wr(3'h0, 8'h41);
      wait_c(4);
      check("pwm_out", 8'(pwm_out), 8'h03);
      check("irq", 8'(irq), 8'h00);
      rd(3'h5, 8'h00, "int_status");
      wr(3'h0, 8'h01);
      set_fault(1'b1);
      wait_c(6);
      check("pwm_out", 8'(pwm_out), 8'h02);
      check("irq", 8'(irq), 8'h00);
      set_fault(1'b0);
      wait_c(4);
   endtask : t_ovr

   task automatic conclude;
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : conclude

   initial begin
      repeat (12) @(posedge clk);
      resetn <= 1'b1;
      t_regs;
      t_duty;
      t_hw;
      t_latch;
      t_sw;
      t_ovr;
      conclude;
   end
   // Whole run is under two hundred cycles; this leaves ample margin
   initial begin
      #20000;
      mismatches++;
      conclude;
   end
endmodule : testbench

bind pasc_top pasc_assertions i_pasc_assertions (.clk(clk), .resetn(resetn),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
   .reg_rdata(reg_rdata), .shutdown_source(shutdown_source), .pwm_out(pwm_out), .irq(irq));
